// file: src/sfx_ctrl.sv
// xip mode control and power-up sequencing of a serial nor flash
//
// Overview of operation
// R1: writing 0 to volatile config bit 3 enables xip, not yet active
// R2: host drives confirm bit low in next fast read; xip becomes active
// R3: in xip each frame is address only, in the current protocol
// R4: confirm bit high leaves xip and sets volatile bit 3 back to 1
// R5: boot setting bits 11:9 selecting xip start the device in xip
// R6: confirm bit is dq0 on the first dummy clock after the address
// R7: dq1 to dq3 are ignored on that first dummy clock
// R8: in extended or dual, reset pin pulse ends xip, restores boot state
// R9: in quad, reset pin pulse is honoured only while deselected
// R10: bursts of 7,9,13,17,25,33 clocks force the confirm bit to 1
// R11: host holds dq0 and dq3 high during each rescue burst
// R12: rescue bursts neither reset nor abort; host then does software reset
// R13: power-on reset holds all logic idle, no instruction answered
// R14: during power-up only status and flag status reads are served
// R15: after power-up: standby, write enable and busy clear, locks zero
// R16: controller ready bit is 0 while an operation runs, 1 after
// R17: power-up polled via status bit 0 or flag bit 7, dq0 in, dq1 out
// R18: once ready, switch to the protocol of the boot setting
// R19: a host unable to poll waits the full ready delay
// R20: after an interrupted subsector erase the ready delay is extended
// R21: during the ready delay hold on, reset pin off, default drive
// R22: fast ramp host waits after write inhibit level before polling
// R23: xip active flag persists over frames, resets unless boot selects xip
`timescale 1ns/1ps
`default_nettype none

module sfx_ctrl
	import sfx_pkg::*;
#(
	parameter int POWER_READY_CYCLES = POWER_READY_CYC,
	parameter int ERASE4K_CYCLES     = ERASE4K_CYC,
	parameter int ERASE32K_CYCLES    = ERASE32K_CYC
) (
	// system
	input  wire logic       mclk,
	input  wire logic       nrst,
	// link
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] dq_i,
	output logic            dq1_o,
	output logic            dq1_oe_n,
	// reset pin
	input  wire logic       reset_pin_n,
	input  wire logic       reset_pin_en,
	// boot setting and straps
	input  wire logic [2:0] boot_xip_sel,
	input  wire logic [1:0] boot_proto,
	input  wire logic       erase_intr_strap,
	input  wire logic       erase_32k_strap,
	// configuration writes and array status
	input  wire logic       vcr_wr_stb,
	input  wire logic       vcr_wr_xip_bit,
	input  wire logic       lock_wr_stb,
	input  wire logic [1:0] lock_wr_data,
	input  wire logic       op_busy,
	input  wire logic       hold_cfg_en,
	input  wire logic       drv_default_cfg,
	// state outputs
	output logic            xip_active,
	output logic            vcr_xip_n,
	output logic [1:0]      active_proto,
	output logic            powering,
	output logic            status_wip,
	output logic            status_wel,
	output logic            flag_ready,
	output logic            write_lock,
	output logic            lock_down,
	output logic            standby,
	output logic            hold_en,
	output logic            reset_pin_live,
	output logic            drive_default,
	output logic            sw_reset_pulse
);

	// lanes used per protocol
	function automatic logic [2:0] proto_lanes(input logic [1:0] p);
		case (p)
			PROTO_DUAL: proto_lanes = 3'h2;
			PROTO_QUAD: proto_lanes = 3'h4;
			default:    proto_lanes = 3'h1;
		endcase
	endfunction

	function automatic logic is_fast_read(input logic [7:0] c);
		is_fast_read = (c == CMD_FAST_READ) || (c == CMD_DUAL_IO_READ) ||
			(c == CMD_QUAD_IO_READ);
	endfunction

	// address lanes of a read: set by command in extended, else by protocol
	function automatic logic [2:0] addr_lanes(input logic [7:0] c, input logic [1:0] p);
		if (p != PROTO_EXT) begin
			addr_lanes = proto_lanes(p);
		end else if (c == CMD_DUAL_IO_READ) begin
			addr_lanes = 3'h2;
		end else if (c == CMD_QUAD_IO_READ) begin
			addr_lanes = 3'h4;
		end else begin
			addr_lanes = 3'h1;
		end
	endfunction

	function automatic logic [5:0] addr_clks(input logic [2:0] lanes);
		case (lanes)
			3'h2:    addr_clks = 6'(ADDR_BITS / 2);
			3'h4:    addr_clks = 6'(ADDR_BITS / 4);
			default: addr_clks = 6'(ADDR_BITS);
		endcase
	endfunction

	// configuration seen by the link; changed only while deselected
	logic       cfg_xip_reg;
	logic [1:0] cfg_proto_reg;
	logic       cfg_powering_reg;

	// link side state
	logic       fresh_reg;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic       ones_reg;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_next;
	logic       cmd_full_reg;
	logic       conf_valid_reg;
	logic       conf_val_reg;
	logic       frame_xip_reg;
	logic [1:0] frame_proto_reg;
	logic [2:0] st_s1_reg;
	logic [2:0] st_s2_reg;
	logic       dq1_reg;
	logic       dq1_oe_n_reg;

	wire        frame_xip  = fresh_reg ? cfg_xip_reg : frame_xip_reg;
	wire  [1:0] frame_proto = fresh_reg ? cfg_proto_reg : frame_proto_reg;
	wire  [5:0] pos        = fresh_reg ? 6'h00 : cnt_reg;
	wire  [2:0] cmd_lanes  = proto_lanes(frame_proto);
	wire  [5:0] cmd_clks   = 6'(8 / cmd_lanes);
	wire  [5:0] conf_pos   = (frame_xip ? 6'h00 : cmd_clks) +
		addr_clks(addr_lanes(cmd_reg, frame_proto));
	wire        in_cmd     = !frame_xip && (pos < cmd_clks);
	wire        conf_hit   = !in_cmd && (pos == conf_pos) && !cfg_powering_reg &&
		(frame_xip || is_fast_read(cmd_reg));
	wire  [7:0] cmd_base   = (fresh_reg && !cfg_xip_reg) ? 8'h00 : cmd_reg;

	// shift command bits in on the lanes of the protocol
	always_comb begin
		case (cmd_lanes)
			3'h2:    cmd_next = {cmd_base[5:0], dq_i[1:0]};
			3'h4:    cmd_next = {cmd_base[3:0], dq_i[3:0]};
			default: cmd_next = {cmd_base[6:0], dq_i[0]};
		endcase
	end

	assign cnt_next = fresh_reg ? 6'h01 : ((cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 6'h01);

	// set by deselect, cleared at the first clock of a frame
	always_ff @(posedge sclk or posedge cs_n or negedge nrst) begin
		if (!nrst) begin
			fresh_reg <= 1'b1;
		end else if (cs_n) begin
			fresh_reg <= 1'b1;
		end else begin
			fresh_reg <= 1'b0;
		end
	end

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg         <= 6'h00;
			ones_reg        <= 1'b0;
			frame_xip_reg   <= 1'b0;
			frame_proto_reg <= PROTO_EXT;
		end else begin
			cnt_reg         <= cnt_next;
			ones_reg        <= (fresh_reg | ones_reg) & dq_i[0] & dq_i[3]; // R10 R11
			frame_xip_reg   <= frame_xip;
			frame_proto_reg <= frame_proto;
		end
	end

	// xip frames skip the command phase and reuse the last read code
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg      <= 8'h00;
			cmd_full_reg <= 1'b0;
		end else begin
			if (in_cmd) begin
				cmd_reg <= cmd_next;
			end
			cmd_full_reg <= frame_xip ? 1'b0 : (!in_cmd || (pos == cmd_clks - 6'h01)); // R3
		end
	end

	// confirm bit: dq0 only, first dummy clock after the address
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			conf_valid_reg <= 1'b0;
			conf_val_reg   <= 1'b0;
		end else if (conf_hit) begin
			conf_valid_reg <= 1'b1; // R6
			conf_val_reg   <= dq_i[0]; // R7
		end else if (fresh_reg) begin
			conf_valid_reg <= 1'b0;
			conf_val_reg   <= 1'b0;
		end
	end

	// status bits into the link domain
	logic [2:0] st_bits_reg;

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			st_s1_reg <= 3'h0;
			st_s2_reg <= 3'h0;
		end else begin
			st_s1_reg <= st_bits_reg;
			st_s2_reg <= st_s1_reg;
		end
	end

	wire  [7:0] status_byte = 8'(st_s2_reg[0]) << STATUS_WIP_BIT |
		8'(st_s2_reg[1]) << STATUS_WEL_BIT;
	wire  [7:0] flag_byte   = 8'(st_s2_reg[2]) << FLAG_READY_BIT;
	wire        rd_status   = !frame_xip_reg && (cmd_reg == CMD_READ_STATUS);
	wire        rd_flag     = !frame_xip_reg && (cmd_reg == CMD_READ_FLAG);
	wire        out_ok      = (cnt_reg >= 6'h08) && (frame_proto_reg == PROTO_EXT) &&
		(rd_status || rd_flag);
	wire  [2:0] out_idx     = ~cnt_reg[2:0];
	wire  [7:0] out_byte    = rd_flag ? flag_byte : status_byte;

	// status data out on dq1, launched on the falling clock edge
	always_ff @(negedge sclk or posedge cs_n or negedge nrst) begin
		if (!nrst) begin
			dq1_reg      <= 1'b0;
			dq1_oe_n_reg <= 1'b1;
		end else if (cs_n) begin
			dq1_reg      <= 1'b0;
			dq1_oe_n_reg <= 1'b1;
		end else begin
			dq1_reg      <= out_ok ? out_byte[out_idx] : 1'b0; // R17
			dq1_oe_n_reg <= !out_ok;
		end
	end

	assign dq1_o    = dq1_reg;
	assign dq1_oe_n = dq1_oe_n_reg;

	// pin synchronisers
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic rp_s1_reg;
	logic rp_s2_reg;
	logic rp_s3_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			rp_s1_reg <= 1'b1;
			rp_s2_reg <= 1'b1;
			rp_s3_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			rp_s1_reg <= reset_pin_n;
			rp_s2_reg <= rp_s1_reg;
			rp_s3_reg <= rp_s2_reg;
		end
	end

	// power-up sequencing
	sfx_pu_state_t pu_state_reg;
	sfx_pu_state_t pu_state_next;
	logic [23:0]   timer_reg;
	logic [23:0]   timer_next;
	logic          strap_taken_reg;
	logic          erase_intr_reg;
	logic          erase_32k_reg;

	wire        timer_zero  = (timer_reg == 24'h000000);
	wire [23:0] recover_cyc = erase_32k_reg ? 24'(ERASE32K_CYCLES) : 24'(ERASE4K_CYCLES);
	wire        enter_ready = (pu_state_reg != PU_READY) && (pu_state_next == PU_READY);
	wire        pwr         = (pu_state_reg != PU_READY);

	always_comb begin
		pu_state_next = pu_state_reg;
		timer_next    = timer_zero ? timer_reg : timer_reg - 24'h000001;
		case (pu_state_reg)
			PU_WAIT: begin
				if (timer_zero && erase_intr_reg) begin
					pu_state_next = PU_RECOVER; // R20
					timer_next    = recover_cyc;
				end else if (timer_zero) begin
					pu_state_next = PU_READY;
				end
			end
			PU_RECOVER: begin
				if (timer_zero) begin
					pu_state_next = PU_READY;
				end
			end
			PU_READY: begin
				pu_state_next = PU_READY;
			end
			default: begin
				pu_state_next = PU_WAIT;
			end
		endcase
	end

	// power-on reset holds everything in the waiting state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pu_state_reg <= PU_WAIT; // R13
			timer_reg    <= 24'(POWER_READY_CYCLES);
		end else begin
			pu_state_reg <= pu_state_next;
			timer_reg    <= timer_next;
		end
	end

	// straps caught once after reset release
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_taken_reg <= 1'b0;
			erase_intr_reg  <= 1'b0;
			erase_32k_reg   <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			erase_intr_reg  <= erase_intr_strap;
			erase_32k_reg   <= erase_32k_strap;
		end
	end

	// frame end decoding
	logic       xip_reg;
	logic       vcr_xip_n_reg;
	logic [1:0] proto_reg;
	logic       rst_armed_reg;

	wire boot_xip   = (boot_xip_sel != BOOT_XIP_OFF);
	wire frame_end  = cs_s2_reg && !cs_s3_reg && !pwr;
	wire cmd_frame  = frame_end && cmd_full_reg && !frame_xip_reg; // R14
	wire rescue_hit = frame_end && ones_reg && ((cnt_reg == RESCUE_7) ||
		(cnt_reg == RESCUE_9) || (cnt_reg == RESCUE_13) || (cnt_reg == RESCUE_17) ||
		(cnt_reg == RESCUE_25) || (cnt_reg == RESCUE_33));
	wire conf_exit  = frame_end && conf_valid_reg && conf_val_reg;
	wire conf_enter = frame_end && conf_valid_reg && (conf_val_reg == CONFIRM_STAY) &&
		(frame_xip_reg || (vcr_xip_n_reg == VCR_XIP_ENABLE));
	wire pin_pulse  = !rp_s2_reg && rp_s3_reg;
	wire pin_reset  = pin_pulse && reset_pin_en && !pwr &&
		((proto_reg != PROTO_QUAD) || cs_s2_reg);
	wire sw_reset   = cmd_frame && rst_armed_reg && (cmd_reg == CMD_RESET_MEMORY);
	wire restore    = pin_reset || sw_reset;

	// restore to boot state wins over link events
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			xip_reg <= 1'b0;
		end else if (restore || enter_ready) begin
			xip_reg <= boot_xip; // R5 R8 R9 R23
		end else if (rescue_hit || conf_exit) begin
			xip_reg <= 1'b0; // R4 R10 R12
		end else if (conf_enter) begin
			xip_reg <= 1'b1; // R2
		end
	end

	// hardware setting of the xip bit wins over a software write
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			vcr_xip_n_reg <= VCR_XIP_RESET;
		end else if (restore || rescue_hit || conf_exit) begin
			vcr_xip_n_reg <= VCR_XIP_RESET; // R4
		end else if (vcr_wr_stb && !pwr) begin
			vcr_xip_n_reg <= vcr_wr_xip_bit; // R1
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			proto_reg     <= PROTO_EXT;
			rst_armed_reg <= 1'b0;
		end else begin
			if (restore || enter_ready) begin
				proto_reg <= boot_proto; // R18
			end
			if (restore) begin
				rst_armed_reg <= 1'b0;
			end else if (cmd_frame) begin
				rst_armed_reg <= (cmd_reg == CMD_RESET_ENABLE);
			end
		end
	end

	// link configuration updated only while deselected
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_xip_reg      <= 1'b0;
			cfg_proto_reg    <= PROTO_EXT;
			cfg_powering_reg <= 1'b1;
		end else if (cs_s2_reg && !frame_end) begin
			cfg_xip_reg      <= xip_reg;
			cfg_proto_reg    <= pwr ? PROTO_EXT : proto_reg; // R21
			cfg_powering_reg <= pwr && !enter_ready;
		end
	end

	// status, locks and pin behaviour
	logic wel_reg;
	logic wip_reg;
	logic ready_reg;
	logic wlock_reg;
	logic ldown_reg;
	logic standby_reg;
	logic hold_reg;
	logic rp_live_reg;
	logic drv_reg;
	logic swr_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wel_reg   <= 1'b0;
			wlock_reg <= 1'b0;
			ldown_reg <= 1'b0;
		end else if (enter_ready || restore) begin
			wel_reg   <= 1'b0; // R15
			wlock_reg <= 1'b0;
			ldown_reg <= 1'b0;
		end else begin
			if (cmd_frame && (cmd_reg == CMD_WRITE_ENABLE)) begin
				wel_reg <= 1'b1;
			end else if (cmd_frame && (cmd_reg == CMD_WRITE_DISBL)) begin
				wel_reg <= 1'b0;
			end
			if (lock_wr_stb && !pwr) begin
				wlock_reg <= lock_wr_data[0];
				ldown_reg <= lock_wr_data[1];
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wip_reg     <= 1'b1;
			ready_reg   <= 1'b0;
			standby_reg <= 1'b0;
			hold_reg    <= 1'b1;
			rp_live_reg <= 1'b0;
			drv_reg     <= 1'b1;
			swr_reg     <= 1'b0;
			st_bits_reg <= 3'h1;
		end else begin
			wip_reg     <= pwr || op_busy; // R17
			ready_reg   <= !pwr && !op_busy; // R16
			standby_reg <= !pwr && !op_busy && cs_s2_reg; // R15
			hold_reg    <= pwr || hold_cfg_en; // R21
			rp_live_reg <= !pwr && reset_pin_en; // R21
			drv_reg     <= pwr || drv_default_cfg; // R21
			swr_reg     <= sw_reset; // R12
			st_bits_reg <= {!pwr && !op_busy, wel_reg, pwr || op_busy};
		end
	end

	assign xip_active     = xip_reg;
	assign vcr_xip_n      = vcr_xip_n_reg;
	assign active_proto   = proto_reg;
	assign powering       = cfg_powering_reg;
	assign status_wip     = wip_reg;
	assign status_wel     = wel_reg;
	assign flag_ready     = ready_reg;
	assign write_lock     = wlock_reg;
	assign lock_down      = ldown_reg;
	assign standby        = standby_reg;
	assign hold_en        = hold_reg;
	assign reset_pin_live = rp_live_reg;
	assign drive_default  = drv_reg;
	assign sw_reset_pulse = swr_reg;

endmodule

`default_nettype wire

// file: src/sfx_pkg.sv
// constants and types shared by the flash xip and power-up controller
package sfx_pkg;

	// serial protocols
	typedef enum logic [1:0] {
		PROTO_EXT  = 2'b00,
		PROTO_DUAL = 2'b01,
		PROTO_QUAD = 2'b10
	} sfx_proto_t;

	// power-up sequencing states
	typedef enum logic [1:0] {
		PU_WAIT    = 2'b00,
		PU_RECOVER = 2'b01,
		PU_READY   = 2'b10
	} sfx_pu_state_t;

	// command codes seen on the link
	localparam logic [7:0] CMD_FAST_READ    = 8'h0B;
	localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
	localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h05;
	localparam logic [7:0] CMD_READ_FLAG    = 8'h70;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISBL  = 8'h04;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET_MEMORY = 8'h99;

	// volatile configuration xip bit: 0 enables xip
	localparam int         VCR_XIP_BIT     = 3;
	localparam logic       VCR_XIP_RESET   = 1'b1;
	localparam logic       VCR_XIP_ENABLE  = 1'b0;
	// boot setting field value that leaves xip off (erased)
	localparam logic [2:0] BOOT_XIP_OFF    = 3'h7;
	localparam logic       CONFIRM_STAY    = 1'b0;

	// status and flag status bit positions
	localparam int         STATUS_WIP_BIT  = 0;
	localparam int         STATUS_WEL_BIT  = 1;
	localparam int         FLAG_READY_BIT  = 7;

	// link framing
	localparam int         ADDR_BITS       = 24;
	localparam logic [5:0] CNT_MAX         = 6'h3F;
	localparam logic [5:0] RESCUE_7        = 6'h07;
	localparam logic [5:0] RESCUE_9        = 6'h09;
	localparam logic [5:0] RESCUE_13       = 6'h0D;
	localparam logic [5:0] RESCUE_17       = 6'h11;
	localparam logic [5:0] RESCUE_25       = 6'h19;
	localparam logic [5:0] RESCUE_33       = 6'h21;

	// timing
	localparam int MCLK_MHZ            = 250;
	localparam int POWER_READY_US      = 300;
	localparam int ERASE4K_RECOVER_US  = 4500;
	localparam int ERASE32K_RECOVER_US = 36000;
	localparam int POWER_READY_CYC     = POWER_READY_US * MCLK_MHZ;
	localparam int ERASE4K_CYC         = ERASE4K_RECOVER_US * MCLK_MHZ;
	localparam int ERASE32K_CYC        = ERASE32K_RECOVER_US * MCLK_MHZ;

endpackage

// file: tb/sfx_ctrl_props.sv
// assertions on the xip and power-up controller ports
`timescale 1ns/1ps
`default_nettype none

module sfx_ctrl_props
	import sfx_pkg::*;
#(
	parameter int POWER_READY_CYCLES = POWER_READY_CYC,
	parameter int ERASE4K_CYCLES     = ERASE4K_CYC,
	parameter int ERASE32K_CYCLES    = ERASE32K_CYC
) (
	// system
	input wire logic       mclk,
	input wire logic       nrst,
	// watched inputs
	input wire logic       cs_n,
	input wire logic       op_busy,
	input wire logic [1:0] boot_proto,
	// watched outputs
	input wire logic       dq1_oe_n,
	input wire logic       xip_active,
	input wire logic       vcr_xip_n,
	input wire logic [1:0] active_proto,
	input wire logic       powering,
	input wire logic       status_wip,
	input wire logic       status_wel,
	input wire logic       flag_ready,
	input wire logic       write_lock,
	input wire logic       lock_down,
	input wire logic       standby,
	input wire logic       hold_en,
	input wire logic       reset_pin_live,
	input wire logic       drive_default,
	input wire logic       sw_reset_pulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	pu_busy_a: assert property (powering |-> status_wip && !flag_ready)
		else $error("busy flags wrong while powering");
	pu_pins_a: assert property (powering |-> hold_en && !reset_pin_live && drive_default)
		else $error("pin settings wrong while powering");
	pu_xip_off_a: assert property (powering |-> !xip_active && vcr_xip_n)
		else $error("xip state moved while powering");
	ready_clean_a: assert property ($fell(powering) |-> !status_wel && !write_lock && !lock_down)
		else $error("latch or locks set at ready");
	standby_ready_a: assert property (standby |-> !powering)
		else $error("standby during power-up");
	busy_flag_a: assert property (op_busy [*2] |-> !flag_ready && status_wip)
		else $error("ready shown while busy");
	done_flag_a: assert property ((!op_busy && !powering) [*3] |-> flag_ready && !status_wip)
		else $error("ready not shown when idle");
	proto_boot_a: assert property ($changed(active_proto) |-> active_proto == boot_proto)
		else $error("protocol not taken from boot setting");
	exit_vcr_a: assert property ($fell(xip_active) |-> ##[0:1] vcr_xip_n)
		else $error("volatile xip bit not restored on exit");
	swr_pulse_a: assert property (sw_reset_pulse |=> !sw_reset_pulse)
		else $error("software reset pulse too long");
	oe_idle_a: assert property (cs_n [*3] |-> dq1_oe_n)
		else $error("dq1 driven while deselected");

	cover property ($fell(powering));
	cover property ($rose(xip_active));
	cover property ($fell(xip_active) && op_busy);
	cover property (sw_reset_pulse);
endmodule

bind sfx_ctrl sfx_ctrl_props #(
	.POWER_READY_CYCLES(POWER_READY_CYCLES),
	.ERASE4K_CYCLES(ERASE4K_CYCLES),
	.ERASE32K_CYCLES(ERASE32K_CYCLES)
) u_sfx_ctrl_props (
	.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .op_busy(op_busy), .boot_proto(boot_proto),
	.dq1_oe_n(dq1_oe_n), .xip_active(xip_active), .vcr_xip_n(vcr_xip_n),
	.active_proto(active_proto), .powering(powering), .status_wip(status_wip),
	.status_wel(status_wel), .flag_ready(flag_ready), .write_lock(write_lock),
	.lock_down(lock_down), .standby(standby), .hold_en(hold_en),
	.reset_pin_live(reset_pin_live), .drive_default(drive_default),
	.sw_reset_pulse(sw_reset_pulse)
);

`default_nettype wire

// file: tb/sfx_ctrl_tb.sv
// self-checking bench for the xip and power-up controller
`timescale 1ns/1ps
`default_nettype none

module sfx_ctrl_tb
	import sfx_pkg::*;
;
	localparam int PRC   = 300;
	localparam int E4    = 400;
	localparam int E32   = 500;
	localparam int LIMIT = 20000;

	logic       mclk;
	logic       nrst;
	logic       reset_pin_n;
	logic       rp_en = 1'b1;
	logic [2:0] boot_xip_sel;
	logic [1:0] boot_proto;
	logic       erase_intr_strap;
	logic       erase_32k_strap;
	logic       vcr_wr_stb;
	logic       vcr_wr_xip_bit;
	logic       lock_wr_stb;
	logic [1:0] lock_wr_data;
	logic       op_busy;
	logic       sw_seen;
	logic [7:0] rd;
	wire        sclk, cs_n, dq1_o, dq1_oe_n, xip_active, vcr_xip_n, powering, status_wip;
	wire        status_wel, flag_ready, write_lock, lock_down, standby, hold_en;
	wire        reset_pin_live, drive_default, sw_reset_pulse;
	wire  [1:0] active_proto;
	wire  [3:0] h_dq;
	wire  [3:0] dq_line = {h_dq[3:2], dq1_oe_n ? h_dq[1] : dq1_o, h_dq[0]};
	int         n_mismatch;
	int         cmp_count;
	int         tick;
	int         cyc;
	int         bursts[6] = '{7, 9, 13, 17, 25, 33};

	sfx_ctrl #(.POWER_READY_CYCLES(PRC), .ERASE4K_CYCLES(E4), .ERASE32K_CYCLES(E32)) u_sfx_ctrl (
		.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_line), .dq1_o(dq1_o),
		.dq1_oe_n(dq1_oe_n), .reset_pin_n(reset_pin_n), .reset_pin_en(rp_en),
		.boot_xip_sel(boot_xip_sel), .boot_proto(boot_proto),
		.erase_intr_strap(erase_intr_strap), .erase_32k_strap(erase_32k_strap),
		.vcr_wr_stb(vcr_wr_stb), .vcr_wr_xip_bit(vcr_wr_xip_bit), .lock_wr_stb(lock_wr_stb),
		.lock_wr_data(lock_wr_data), .op_busy(op_busy), .hold_cfg_en(1'b0),
		.drv_default_cfg(1'b0), .xip_active(xip_active), .vcr_xip_n(vcr_xip_n),
		.active_proto(active_proto), .powering(powering), .status_wip(status_wip),
		.status_wel(status_wel), .flag_ready(flag_ready), .write_lock(write_lock),
		.lock_down(lock_down), .standby(standby), .hold_en(hold_en),
		.reset_pin_live(reset_pin_live), .drive_default(drive_default),
		.sw_reset_pulse(sw_reset_pulse)
	);

	sfx_host u_sfx_host (.sclk(sclk), .cs_n(cs_n), .dq(h_dq), .dq1(dq_line[1]));

	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	always @(posedge mclk) begin
		tick <= tick + 1;
		cyc  <= nrst ? cyc + 1 : 0;
		if (sw_reset_pulse === 1'b1)
			sw_seen <= 1'b1;
		if (tick == LIMIT) begin
			n_mismatch = n_mismatch + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic clk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic rst(input logic [2:0] xs, input logic [1:0] pr, input logic [1:0] st);
		@(posedge mclk);
		nrst                               <= 1'b0;
		boot_xip_sel                       <= xs;
		boot_proto                         <= pr;
		{erase_32k_strap, erase_intr_strap} <= st;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
	endtask

	task automatic wait_ready();
		for (int i = 0; i < 2000 && flag_ready !== 1'b1; i++)
			@(negedge mclk);
	endtask

	task automatic fr(input logic [63:0] d, input int n, input int w);
		u_sfx_host.frame(d, n, w, rd);
		clk(6);
	endtask

	task automatic vcr(input logic b);
		@(posedge mclk);
		vcr_wr_stb     <= 1'b1;
		vcr_wr_xip_bit <= b;
		@(posedge mclk);
		vcr_wr_stb <= 1'b0;
		clk(2);
	endtask

	task automatic enter_xip();
		vcr(VCR_XIP_ENABLE);
		chk({vcr_xip_n, xip_active}, 2'b00);
		fr({CMD_FAST_READ, 24'h123456, CONFIRM_STAY}, 33, 1);
		chk(xip_active, 1'b1);
	endtask

	task automatic rpin();
		@(posedge mclk);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_pin_n <= 1'b1;
		clk(8);
	endtask

	initial begin
		nrst             = 1'b0;
		reset_pin_n      = 1'b1;
		boot_xip_sel     = BOOT_XIP_OFF;
		boot_proto       = PROTO_EXT;
		erase_intr_strap = 1'b0;
		erase_32k_strap  = 1'b0;
		vcr_wr_stb       = 1'b0;
		vcr_wr_xip_bit   = 1'b1;
		lock_wr_stb      = 1'b0;
		lock_wr_data     = 2'b00;
		op_busy          = 1'b0;
		sw_seen          = 1'b0;
		n_mismatch       = 0;
		cmp_count        = 0;
		tick             = 0;
		cyc              = 0;
		clk(2);
		chk({powering, status_wip, flag_ready, xip_active, vcr_xip_n, hold_en,
			reset_pin_live, drive_default}, 8'hCD);
		chk({dq1_oe_n, active_proto, sw_reset_pulse}, 4'h8);
		@(posedge mclk) nrst <= 1'b1;
		for (int s = 2; s >= 0; s--) begin
			rst(BOOT_XIP_OFF, PROTO_EXT, {s == 2, s != 0});
			if (s == 0) begin
				clk(20);
				fr({CMD_READ_STATUS, 8'h00}, 16, 1);
				chk(rd[1:0], 2'b01);
				fr(CMD_WRITE_ENABLE, 8, 1);
				fr({CMD_READ_STATUS, 8'h00}, 16, 1);
				chk(rd[1:0], 2'b01);
				fr({CMD_READ_FLAG, 8'h00}, 16, 1);
				chk(rd[7], 1'b0);
			end
			wait_ready();
			chk(cyc >= PRC + (s == 1 ? E4 : 0) + (s == 2 ? E32 : 0), 1'b1);
			chk(cyc <= PRC + (s == 1 ? E4 : 0) + (s == 2 ? E32 : 0) + 6, 1'b1);
		end
		clk(3);
		chk({standby, status_wel, write_lock, lock_down, status_wip, hold_en,
			reset_pin_live, drive_default}, 8'h82);
		chk(active_proto, PROTO_EXT);
		fr(CMD_WRITE_ENABLE, 8, 1);
		fr({CMD_READ_STATUS, 8'h00}, 16, 1);
		chk({rd[1:0], status_wel}, 3'b101);
		@(posedge mclk) op_busy <= 1'b1;
		clk(3);
		chk({flag_ready, status_wip}, 2'b01);
		fr({CMD_READ_FLAG, 8'h00}, 16, 1);
		chk(rd[7], 1'b0);
		@(posedge mclk) op_busy <= 1'b0;
		clk(3);
		fr({CMD_READ_FLAG, 8'h00}, 16, 1);
		chk(rd[7], 1'b1);
		@(posedge mclk) lock_wr_stb <= 1'b1;
		lock_wr_data <= 2'b11;
		@(posedge mclk) lock_wr_stb <= 1'b0;
		clk(2);
		chk({write_lock, lock_down}, 2'b11);
		enter_xip();
		fr({24'h00ABCD, CONFIRM_STAY}, 25, 1);
		chk(xip_active, 1'b1);
		fr({24'h00ABCD, 1'b1}, 25, 1);
		chk({xip_active, vcr_xip_n}, 2'b01);
		@(posedge mclk) op_busy <= 1'b1;
		sw_seen = 1'b0;
		foreach (bursts[k]) begin
			enter_xip();
			fr({64{1'b1}}, bursts[k], 1);
			chk({xip_active, vcr_xip_n, flag_ready, sw_seen}, 4'b0100);
		end
		@(posedge mclk) op_busy <= 1'b0;
		fr(CMD_RESET_ENABLE, 8, 1);
		fr(CMD_RESET_MEMORY, 8, 1);
		chk(sw_seen, 1'b1);
		wait_ready();
		enter_xip();
		rpin();
		chk({xip_active, vcr_xip_n, active_proto}, {2'b01, PROTO_EXT});
		rst(3'h0, PROTO_QUAD, 2'b00);
		wait_ready();
		clk(3);
		chk({xip_active, active_proto}, {1'b1, PROTO_QUAD});
		fr({24'h000040, 4'b1110}, 7, 4);
		chk(xip_active, 1'b1);
		fr({24'h000040, 4'b0001}, 7, 4);
		chk(xip_active, 1'b0);
		fork
			fr(64'h0, 16, 4);
			begin
				clk(6);
				rpin();
			end
		join
		chk(xip_active, 1'b0);
		rp_en <= 1'b0;
		rpin();
		chk({xip_active, reset_pin_live}, 2'b00);
		rp_en <= 1'b1;
		rpin();
		chk(xip_active, 1'b1);
		give_verdict();
	end
endmodule

`default_nettype wire

// file: tb/sfx_host.sv
// host side link model: frames, rescue bursts, status reads
`timescale 1ns/1ps
`default_nettype none

module sfx_host (
	// link
	output var logic       sclk,
	output var logic       cs_n,
	output var logic [3:0] dq,
	input  wire logic      dq1
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq   = 4'hA;
	end

	// n clocks of w lanes, data right aligned, msb first; rd from clocks 9..16
	task automatic frame(input logic [63:0] d, input int n, input int w, output logic [7:0] rd);
		logic [3:0] m;
		m    = 4'((1 << w) - 1);
		rd   = 8'h00;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			dq = (4'(d >> ((n - 1 - i) * w)) & m) | (~m & {2'b11, ~dq[1], 1'b0});
			#3 sclk = 1'b1;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], dq1};
			#3 sclk = 1'b0;
		end
		#3 cs_n = 1'b1;
		// released lines show the inverse
		dq = ~dq;
		#40;
	endtask
endmodule

`default_nettype wire
